// ===== logic/aclk_pkg.sv
// Constants shared by the adaptive clock generator register block.
`default_nettype none
package aclk_pkg;
   localparam int unsigned ADDR_W           = 16;
   localparam int unsigned DATA_W           = 8;
   localparam int unsigned FREQ_W           = 24;
   localparam int unsigned COUNT_W          = 16;
   localparam logic [15:0] OFS_SOURCE_SEL   = 16'hffe0;
   localparam logic [15:0] OFS_DIV_CTRL     = 16'hffe2;
   localparam logic [15:0] OFS_CAP_HIGH     = 16'hffe3;
   localparam logic [15:0] OFS_CAP_LOW      = 16'hffe4;
   localparam logic [15:0] OFS_FREQ_HIGH    = 16'hffe5;
   localparam logic [15:0] OFS_FREQ_MIDDLE  = 16'hffe6;
   localparam logic [15:0] OFS_FREQ_LOW     = 16'hffe7;
   localparam int unsigned OUT_DIV_LSB      = 4;
   localparam int unsigned OUT_DIV_W        = 4;
   localparam int unsigned IN_DIV_LSB       = 0;
   localparam int unsigned IN_DIV_W         = 3;
   localparam int unsigned RESERVED_BIT     = 3;
   localparam int unsigned SOURCE_SEL_BIT   = 0;
   localparam logic [7:0]  RST_BYTE         = 8'h00;
   localparam logic [23:0] RST_FREQ         = 24'h00_0000;
   localparam logic [15:0] RST_COUNT        = 16'h0000;
   localparam logic [3:0]  RST_DIV_CNT      = 4'h0;
   typedef enum logic {
      ACLK_SRC_MAIN,
      ACLK_SRC_ALT
   } aclk_src_t;
endpackage
`default_nettype wire

// ===== logic/aclk_regs.sv
// Register, synthesizer, divider and frame capture logic of the clock block.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The low byte of the frequency word is a read-write register that resets to zero.
// - Bits 15 to 8 of the frequency word live in the read-write middle frequency register.
// - Bits 23 to 16 of the frequency word live in the read-write high frequency register.
// - The full frequency word steers the synthesizer that makes the master clock output.
// - A 16-bit counter free-runs and advances on every rising edge of the selected clock.
// - At every start of frame the counter value is copied into the capture registers.
// - Software picks the counter clock as either the master clock or its alternate output.
// - Only the frame start updates the capture, writes are ignored and reset clears it.
// - The low capture register shows bits 7 to 0 of the captured count.
// - The high capture register shows bits 15 to 8 of the captured count.
// - The master clock output is divided by the four-bit field in bits 7 to 4 plus one.
// - The master clock input is divided by the three-bit field in bits 2 to 0 plus one.
// - Bit 3 of the divider control register is reserved and always reads zero.
module aclk_regs #(
   parameter int unsigned COUNT_W = aclk_pkg::COUNT_W,
   parameter int unsigned FREQ_W  = aclk_pkg::FREQ_W
) (
   // Clock and reset.
   input  wire logic                      clk,
   input  wire logic                      resetn,
   // Register port.
   input  wire logic [aclk_pkg::ADDR_W-1:0] addr,
   input  wire logic [aclk_pkg::DATA_W-1:0] wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   output logic      [aclk_pkg::DATA_W-1:0] rdata,
   // Frame timer.
   input  wire logic                      start_of_frame,
   // Codec clocks.
   input  wire logic                      codec_master_clock_in,
   output logic                           codec_master_clock_in_div,
   output logic                           codec_master_clock_out,
   output logic                           codec_master_clock_alt_out
);

   // ************************************************************
   // Parameter check.
   // ************************************************************
   generate
      if (COUNT_W != 16 || FREQ_W != 24) begin : g_bad_width
         $error("Widths must match the two capture and three frequency bytes.");
      end
      if (aclk_pkg::ADDR_W != 16 || aclk_pkg::DATA_W != 8) begin : g_bad_bus
         $error("The register port needs a 16-bit address and 8-bit data.");
      end
      if (aclk_pkg::OUT_DIV_W != 4 || aclk_pkg::IN_DIV_W != 3) begin : g_dw
         $error("The divider fields must be four and three bits wide.");
      end
      if (aclk_pkg::OUT_DIV_LSB + aclk_pkg::OUT_DIV_W > 8) begin : g_out_fld
         $error("The output divider field must fit in the data byte.");
      end
      if (aclk_pkg::IN_DIV_LSB + aclk_pkg::IN_DIV_W > 3) begin : g_in_fld
         $error("The input divider field must stay below the reserved bit.");
      end
      if (aclk_pkg::RESERVED_BIT != 3) begin : g_rsv_bit
         $error("The reserved bit of the divider byte must be bit 3.");
      end
   endgenerate

   // ************************************************************
   // Divider helper.
   // ************************************************************
   // Returns the next edge count of a divider that wraps after div.
   function automatic logic [3:0] div_step(input logic [3:0] cnt,
                                           input logic [3:0] div);
      logic [3:0] res;
      res = 4'h0;
      if (cnt < div) begin
         res = 4'(cnt + 4'h1);
      end
      return res;
   endfunction

   // Returns high on the clock cycle in which a sampled level has risen.
   function automatic logic rise(input logic cur,
                                 input logic prev);
      return cur && !prev;
   endfunction

   // Returns high when a strobe is present at the given offset.
   function automatic logic reg_hit(input logic [15:0] a,
                                    input logic [15:0] ofs,
                                    input logic        strobe);
      return strobe && (a == ofs);
   endfunction

   // ************************************************************
   // Registers.
   // ************************************************************
   logic [7:0]         freq_low_r;
   logic [7:0]         freq_mid_r;
   logic [7:0]         freq_high_r;
   logic [3:0]         out_div_r;
   logic [2:0]         in_div_r;
   logic               src_sel_r;
   logic [15:0]        captured_count_r;
   logic [7:0]         rdata_r;

   // ************************************************************
   // Write decode.
   // ************************************************************
   logic wr_freq_low;
   logic wr_freq_mid;
   logic wr_freq_high;
   logic wr_div_ctrl;
   logic wr_src_sel;

   assign wr_freq_low  = reg_hit(addr, aclk_pkg::OFS_FREQ_LOW, wr);
   assign wr_freq_mid  = reg_hit(addr, aclk_pkg::OFS_FREQ_MIDDLE, wr);
   assign wr_freq_high = reg_hit(addr, aclk_pkg::OFS_FREQ_HIGH, wr);
   assign wr_div_ctrl  = reg_hit(addr, aclk_pkg::OFS_DIV_CTRL, wr);
   assign wr_src_sel   = reg_hit(addr, aclk_pkg::OFS_SOURCE_SEL, wr);

   // ************************************************************
   // Frequency word.
   // ************************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         freq_low_r <= aclk_pkg::RST_BYTE;
      end else if (wr_freq_low) begin
         freq_low_r <= wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         freq_mid_r <= aclk_pkg::RST_BYTE;
      end else if (wr_freq_mid) begin
         freq_mid_r <= wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         freq_high_r <= aclk_pkg::RST_BYTE;
      end else if (wr_freq_high) begin
         freq_high_r <= wdata;
      end
   end

   // ************************************************************
   // Divider control and source select.
   // ************************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_div_r <= 4'h0;
         in_div_r  <= 3'h0;
      end else if (wr_div_ctrl) begin
         out_div_r <= wdata[aclk_pkg::OUT_DIV_LSB +: 4];
         in_div_r  <= wdata[aclk_pkg::IN_DIV_LSB +: 3];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         src_sel_r <= 1'b0;
      end else if (wr_src_sel) begin
         src_sel_r <= wdata[aclk_pkg::SOURCE_SEL_BIT];
      end
   end

   // ************************************************************
   // Read path.
   // ************************************************************
   logic [7:0] rdata_nxt;

   // Read data stand for the one cycle after the strobe, zero otherwise.
   always_comb begin
      rdata_nxt = aclk_pkg::RST_BYTE;
      if (rd) begin
         case (addr)
            aclk_pkg::OFS_FREQ_LOW: begin
               rdata_nxt = freq_low_r;
            end
            aclk_pkg::OFS_FREQ_MIDDLE: begin
               rdata_nxt = freq_mid_r;
            end
            aclk_pkg::OFS_FREQ_HIGH: begin
               rdata_nxt = freq_high_r;
            end
            aclk_pkg::OFS_CAP_LOW: begin
               rdata_nxt = captured_count_r[7:0];
            end
            aclk_pkg::OFS_CAP_HIGH: begin
               rdata_nxt = captured_count_r[15:8];
            end
            aclk_pkg::OFS_DIV_CTRL: begin
               rdata_nxt = {out_div_r, 1'b0, in_div_r};
            end
            aclk_pkg::OFS_SOURCE_SEL: begin
               rdata_nxt = {7'h00, src_sel_r};
            end
            default: begin
               rdata_nxt = aclk_pkg::RST_BYTE;
            end
         endcase
      end
   end

   // Registering the mux keeps the read data straight off a flip-flop.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= aclk_pkg::RST_BYTE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;

   // ************************************************************
   // Synthesizer.
   // ************************************************************
   logic [23:0] freq_word;
   logic [23:0] phase_r;
   logic        mclk_r;

   assign freq_word = {freq_high_r, freq_mid_r, freq_low_r};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= aclk_pkg::RST_FREQ;
      end else begin
         phase_r <= 24'(phase_r + freq_word);
      end
   end

   // The top bit of the accumulator is the synthesized master clock.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mclk_r <= 1'b0;
      end else begin
         mclk_r <= phase_r[23];
      end
   end

   assign codec_master_clock_out = mclk_r;

   // ************************************************************
   // Output and input dividers.
   // ************************************************************
   logic       mclk_prev_r;
   logic [3:0] out_cnt_r;
   logic       alt_r;
   logic       in_prev_r;
   logic [3:0] in_cnt_r;
   logic       in_div_out_r;
   logic [3:0] out_cnt_nxt;
   logic [3:0] in_cnt_nxt;

   assign out_cnt_nxt = div_step(out_cnt_r, out_div_r);
   assign in_cnt_nxt  = div_step(in_cnt_r, {1'b0, in_div_r});

   // ************************************************************
   // Edge detection.
   // ************************************************************
   // Previous levels of both divider sources for edge detection.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mclk_prev_r <= 1'b0;
         in_prev_r   <= 1'b0;
      end else begin
         mclk_prev_r <= mclk_r;
         in_prev_r   <= codec_master_clock_in;
      end
   end

   // The output divider passes the clock through when its field is zero.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_cnt_r <= aclk_pkg::RST_DIV_CNT;
         alt_r     <= 1'b0;
      end else if (out_div_r == 4'h0) begin
         out_cnt_r <= aclk_pkg::RST_DIV_CNT;
         alt_r     <= mclk_r;
      end else if (rise(mclk_r, mclk_prev_r)) begin
         out_cnt_r <= out_cnt_nxt;
         alt_r     <= (out_cnt_nxt <= (out_div_r >> 1));
      end
   end

   // The input divider passes the clock through when its field is zero.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         in_cnt_r     <= aclk_pkg::RST_DIV_CNT;
         in_div_out_r <= 1'b0;
      end else if (in_div_r == 3'h0) begin
         in_cnt_r     <= aclk_pkg::RST_DIV_CNT;
         in_div_out_r <= codec_master_clock_in;
      end else if (rise(codec_master_clock_in, in_prev_r)) begin
         in_cnt_r     <= in_cnt_nxt;
         in_div_out_r <= (in_cnt_nxt <= {2'b00, in_div_r[2:1]});
      end
   end

   assign codec_master_clock_alt_out = alt_r;
   assign codec_master_clock_in_div  = in_div_out_r;

   // ************************************************************
   // Frame counter and capture.
   // ************************************************************
   logic [15:0] count_r;
   logic        sel_clk;
   logic        sel_prev_r;

   assign sel_clk = src_sel_r ? alt_r : mclk_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_prev_r <= 1'b0;
      end else begin
         sel_prev_r <= sel_clk;
      end
   end

   // The counter wraps at its width and is never reloaded.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_r <= aclk_pkg::RST_COUNT;
      end else if (rise(sel_clk, sel_prev_r)) begin
         count_r <= 16'(count_r + 16'h0001);
      end
   end

   // ************************************************************
   // Capture.
   // ************************************************************
   // The capture only moves on a frame start, keeping both bytes coherent.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         captured_count_r <= aclk_pkg::RST_COUNT;
      end else if (start_of_frame) begin
         captured_count_r <= count_r;
      end
   end

endmodule
`default_nettype wire

// ===== test/aclk_frame_model.sv
// Frame timer and codec input clock model for the clock register bench.
`timescale 1ns/1ps
`default_nettype none
module aclk_frame_model #(
   parameter int FRAME = 128
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic resetn,
   // Frame start and codec input clock.
   output var  logic sof,
   output var  logic mclk_in
);
   int cnt = 0;
   initial sof = 1'b0;
   initial mclk_in = 1'b0;
   always @(posedge clk) begin
      cnt     <= resetn ? (cnt + 1) % FRAME : 0;
      sof     <= resetn && cnt == FRAME - 1;
      mclk_in <= resetn && cnt[1];
   end
endmodule
`default_nettype wire

// ===== test/aclk_regs_chk.sv
// Concurrent checks on the ports of the clock register block.
`timescale 1ns/1ps
`default_nettype none
module aclk_regs_chk (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        resetn,
   // Register port and frame start.
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic        start_of_frame,
   // Codec clocks.
   input wire logic        codec_master_clock_out,
   input wire logic        codec_master_clock_alt_out
);
   logic       seen_r;
   logic [3:0] div_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seen_r <= 1'b0;
         div_r  <= 4'h0;
      end else begin
         seen_r <= seen_r | start_of_frame;
         if (wr && addr == 16'hffe2)
            div_r <= wdata[7:4];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_rsv; rd && addr == 16'hffe2 |=> !rdata[3]; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit");
   property p_dctl; wr && addr == 16'hffe2 ##1 rd && addr == 16'hffe2
      |=> rdata == ($past(wdata, 2) & 8'hf7); endproperty
   a_dctl: assert property (p_dctl) else $error("divider byte");
   property p_low; wr && addr == 16'hffe7 ##1 rd && addr == 16'hffe7
      |=> rdata == $past(wdata, 2); endproperty
   a_low: assert property (p_low) else $error("low byte");
   property p_mid; wr && addr == 16'hffe6 ##1 rd && addr == 16'hffe6
      |=> rdata == $past(wdata, 2); endproperty
   a_mid: assert property (p_mid) else $error("middle byte");
   property p_high; wr && addr == 16'hffe5 ##1 rd && addr == 16'hffe5
      |=> rdata == $past(wdata, 2); endproperty
   a_high: assert property (p_high) else $error("high byte");
   property p_cap0; !seen_r && rd && (addr == 16'hffe3 || addr == 16'hffe4)
      |=> rdata == 8'h00; endproperty
   a_cap0: assert property (p_cap0) else $error("capture not zero");
   property p_coh; rd && addr == 16'hffe4 && !start_of_frame ##1 rd
      && addr == 16'hffe4 |=> rdata == $past(rdata); endproperty
   a_coh: assert property (p_coh) else $error("capture moved");
   property p_alt; (div_r == 4'h0) [*3] |-> codec_master_clock_alt_out
      == $past(codec_master_clock_out); endproperty
   a_alt: assert property (p_alt) else $error("divide by one");
endmodule
`default_nettype wire

// ===== test/tb_aclk_regs.sv
// Self-checking bench for the clock register block.
`timescale 1ns/1ps
`default_nettype none
module tb_aclk_regs;
   logic        clk = 0, resetn = 0, wr = 0, rd = 0, rd_seen = 0, in_prev = 0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00, rdata;
   logic        sof, mclk_in, in_div, mout, alt;
   logic [8:0]  exp_q[$];
   logic [7:0]  got_q[$];
   int          bad_count = 0, comparisons = 0, seed = 32'h07c4;
   int          in_cnt = 0, in_last = 0;
   aclk_regs i_aclk_regs (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
      .start_of_frame(sof), .codec_master_clock_in(mclk_in),
      .codec_master_clock_in_div(in_div), .codec_master_clock_out(mout),
      .codec_master_clock_alt_out(alt));
   aclk_frame_model i_aclk_frame_model (.clk, .resetn, .sof, .mclk_in);
   initial forever #5 clk = ~clk;
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bus(bit w, logic [15:0] a, logic [7:0] d, bit chk = 1);
      @(posedge clk);
      wr    <= w;
      rd    <= !w;
      addr  <= a;
      wdata <= d;
      if (!w) exp_q.push_back({chk, d});
   endtask
   task automatic idle;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic cap(output logic [15:0] c);
      @(posedge sof);
      bus(0, 16'hffe4, 8'h00, 0);
      bus(0, 16'hffe4, 8'h00, 0);
      bus(0, 16'hffe3, 8'h00, 0);
      idle();
      repeat (2) @(negedge clk);
      c[15:8] = got_q.pop_back();
      c[7:0] = got_q.pop_back();
      got_q.delete();
   endtask
   task automatic meas(logic [7:0] dc, logic [7:0] e_out, logic [7:0] e_in);
      logic [15:0] a, b;
      bus(1, 16'hffe2, dc);
      idle();
      cap(a);
      cap(a);
      cap(b);
      check(8'(b - a), e_out);
      check(8'(in_last), e_in);
   endtask
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk) begin
      logic [8:0] e;
      if (rd_seen && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[8]) check(rdata, e[7:0]);
         else got_q.push_back(rdata);
      end
      in_cnt += int'(in_div && !in_prev);
      in_prev = in_div;
      if (sof) begin
         in_last = in_cnt;
         in_cnt  = 0;
      end
   end
   initial begin
      logic [7:0] d;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 2; i < 8; i++) bus(0, 16'hffe0 + 16'(i), 8'h00);
      bus(1, 16'hffe2, 8'hff);
      bus(0, 16'hffe2, 8'hf7);
      for (int i = 3; i < 8; i++) begin
         d = 8'($random(seed));
         bus(1, 16'hffe0 + 16'(i), d);
         bus(0, 16'hffe0 + 16'(i), i < 5 ? 8'h00 : d);
      end
      bus(1, 16'hffe7, 8'h00);
      bus(1, 16'hffe6, 8'h00);
      bus(1, 16'hffe5, 8'h80);
      meas(8'h00, 8'h40, 8'h20);
      bus(1, 16'hffe0, 8'h01);
      meas(8'h00, 8'h40, 8'h20);
      meas(8'h17, 8'h20, 8'h04);
      meas(8'hf1, 8'h04, 8'h10);
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule
bind aclk_regs aclk_regs_chk i_aclk_regs_chk (.clk, .resetn, .addr, .wdata,
   .wr, .rd, .rdata, .start_of_frame, .codec_master_clock_out,
   .codec_master_clock_alt_out);
`default_nettype wire
